// >>> common/psr_map.svh
// Purpose : Offsets, field positions and reset values of the register sync
// Assumes : Byte addressed word registers on a simple local bus
// Notes   : Definitions only
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

// ***************************************************
// Register offsets
// ***************************************************
`define PSR_OFS_CTRL      4'h0
`define PSR_OFS_CFG       4'h4
`define PSR_OFS_PENDING   4'h8

// ***************************************************
// Control word fields
// ***************************************************
`define PSR_BIT_ENABLE    0
`define PSR_BIT_SOFT_RESET_BIT     1
`define PSR_LANE_CTRL     0
`define PSR_LANE_REGA     1
`define PSR_LANE_REGC_LO  2
`define PSR_LANE_REGC_HI  3

// ***************************************************
// Pending flag positions, one per synchronised register
// ***************************************************
`define PSR_SYN_ENABLE    0
`define PSR_SYN_SOFT_RESET_BIT     1
`define PSR_SYN_REGA      2
`define PSR_SYN_REGC      3
`define PSR_NUM_SYNC      4

// ***************************************************
// Reset values
// ***************************************************
`define PSR_RST_REGA      8'h00
`define PSR_RST_REGC      16'h0000
`define PSR_RST_CFG       32'h0000_0000

`endif

// >>> common/psr_pkg.sv
// Purpose : Types shared by the register sync block and its bench
// Assumes : Constants come from psr_map.svh
// Notes   : Nothing here holds a number of its own
`include "psr_map.svh"

package psr_pkg;

  // ***************************************************
  // Bus request and answer
  // ***************************************************
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  byteEn;
  } psr_bus_req_type;

  typedef struct packed {
    logic [31:0] rdData;
    logic        rdValid;
    logic        accessError;
    logic        syncReady;
  } psr_bus_rsp_type;

  // ***************************************************
  // Core side image
  // ***************************************************
  typedef struct packed {
    logic        enable;
    logic        periphReset;
    logic [7:0]  regA;
    logic [15:0] regC;
  } psr_core_type;

  // ***************************************************
  // Whole state of the block
  // ***************************************************
  typedef struct packed {
    logic [2:0]                 gclkSync;
    logic [`PSR_NUM_SYNC-1:0]   reqTog;
    logic [`PSR_NUM_SYNC-1:0]   ackS1;
    logic [`PSR_NUM_SYNC-1:0]   ackS2;
    logic [`PSR_NUM_SYNC-1:0]   ackS3;
    logic [`PSR_NUM_SYNC-1:0]   cReqS1;
    logic [`PSR_NUM_SYNC-1:0]   cReqS2;
    logic [`PSR_NUM_SYNC-1:0]   cReqS3;
    logic [`PSR_NUM_SYNC-1:0]   cReqS4;
    logic [`PSR_NUM_SYNC-1:0]   cReqS5;
    logic [`PSR_NUM_SYNC-1:0]   cAck;
    logic                       shEnable;
    logic                       shSwrst;
    logic [7:0]                 shRegA;
    logic [15:0]                shRegC;
    logic [31:0]                busCfg;
    logic [`PSR_NUM_SYNC-1:0]   pending;
    psr_core_type               core;
    psr_bus_rsp_type            rsp;
  } psr_state_type;

endpackage

// >>> verilog/psr_sync_top.sv
// Purpose : Bus side registers and per-register crossings into a core
//           that runs on the generic clock
// Assumes : The generic clock arrives as a plain input and is sampled;
//           its period is well above three bus clock periods
// Notes   : One bus request per cycle, answered on the following edge
//
// Function
// R1 - Bus-side registers act at once; core register writes always cross
// R2 - Crossing is done even when both clocks share source and rate
// R3 - Every core register owns its own crossing, so writes interleave
// R4 - Writing a register whose crossing is pending drops it, flags error
// R5 - Master waits for a pending crossing before rewriting that register
// R6 - Each writable core register has a pending flag, set while crossing
// R7 - Two byte writes to the 16-bit register: second is refused
// R8 - A word write updates all covered registers, each crossing alone
// R9 - Master checks the pending flag clear before reading core registers
// R10 - Core register reads answer without wait, valid when not pending
// R11 - Polling pending flags or a sync-ready event shows crossing end
// R12 - Enable write starts a crossing and reads back its new value
// R13 - Sync-ready event is not raised for enable crossings
// R14 - Writing one to soft reset crosses, flags pending, reads one
// R15 - Hardware clears soft reset and its flag after core reset; no event
// R16 - Writing zero to soft reset changes nothing
// R17 - Crossing lasts over 5 core plus 2 bus periods, under 6 plus 3
// R18 - Plain bus register access takes two bus periods
// R19 - While the bus interface clock is masked, reads zero, writes ignored
// R20 - Toggle request and acknowledge through two stages each way
`timescale 1ns/1ns
`include "psr_map.svh"

module psr_sync_top #(
  parameter int ADDR_W = 4
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      genericClockIn,
  input  wire logic                      busIfMasked,
  input  wire psr_pkg::psr_bus_req_type  busReq,
  output      psr_pkg::psr_bus_rsp_type  busRsp,
  output      logic [`PSR_NUM_SYNC-1:0]  syncPendingFlags,
  output      psr_pkg::psr_core_type     coreOut
);

  // ***************************************************
  // Elaboration check
  // ***************************************************
  if (ADDR_W != 4) begin : gBadAddr
    $error("psr_sync_top supports ADDR_W of 4 only");
  end

  psr_pkg::psr_state_type state_r;
  psr_pkg::psr_state_type state_nxt;

  logic                     coreTick;
  logic [`PSR_NUM_SYNC-1:0] pendNow;
  logic [`PSR_NUM_SYNC-1:0] ackDone;
  logic                     wrCtrl;
  logic                     laneCtrl;
  logic                     laneRegA;
  logic                     laneRegC;
  logic                     rdCtrl;

  // Core advances only on sampled rising edges of the generic clock
  assign coreTick = state_r.gclkSync[1] & ~state_r.gclkSync[2];
  // Pending while our request toggle differs from the returned acknowledge
  assign pendNow  = state_r.reqTog ^ state_r.ackS2;            // see R20
  assign ackDone  = state_r.ackS2 ^ state_r.ackS3;
  assign wrCtrl   = busReq.valid & busReq.write & ~busIfMasked
                    & (busReq.addr == `PSR_OFS_CTRL);          // see R19
  assign laneCtrl = wrCtrl & busReq.byteEn[`PSR_LANE_CTRL];
  assign laneRegA = wrCtrl & busReq.byteEn[`PSR_LANE_REGA];
  assign laneRegC = wrCtrl & (busReq.byteEn[`PSR_LANE_REGC_LO]
                    | busReq.byteEn[`PSR_LANE_REGC_HI]);
  assign rdCtrl   = busReq.addr == `PSR_OFS_CTRL;

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    logic err;
    err = 1'b0;
    state_nxt = state_r;

    // Generic clock sampler, two stages before any logic looks at it
    state_nxt.gclkSync = {state_r.gclkSync[1:0], genericClockIn};

    // Acknowledge path back to the bus side, two stages then history
    state_nxt.ackS1 = state_r.cAck;                            // see R20
    state_nxt.ackS2 = state_r.ackS1;
    state_nxt.ackS3 = state_r.ackS2;

    // Bus-side image of soft reset ends when its crossing returns
    if (ackDone[`PSR_SYN_SOFT_RESET_BIT] && !pendNow[`PSR_SYN_SOFT_RESET_BIT]) begin
      state_nxt.shSwrst  = 1'b0;                               // see R15
      state_nxt.shEnable = 1'b0;
      state_nxt.shRegA   = `PSR_RST_REGA;
      state_nxt.shRegC   = `PSR_RST_REGC;
      state_nxt.busCfg   = `PSR_RST_CFG;
    end

    // Enable crossing: value readable at once, flag set
    if (laneCtrl) begin
      if (pendNow[`PSR_SYN_ENABLE]) begin
        err = 1'b1;                                            // see R4
      end else begin
        state_nxt.shEnable = busReq.wdata[`PSR_BIT_ENABLE];    // see R12
        state_nxt.reqTog[`PSR_SYN_ENABLE] =
          ~state_r.reqTog[`PSR_SYN_ENABLE];
      end
      // Zero written to soft reset launches nothing
      if (busReq.wdata[`PSR_BIT_SOFT_RESET_BIT]) begin                 // see R16
        if (pendNow[`PSR_SYN_SOFT_RESET_BIT]) begin
          err = 1'b1;                                          // see R4
        end else begin
          state_nxt.shSwrst = 1'b1;                            // see R14
          state_nxt.reqTog[`PSR_SYN_SOFT_RESET_BIT] =
            ~state_r.reqTog[`PSR_SYN_SOFT_RESET_BIT];
        end
      end
    end

    // Independent crossings for the data registers
    if (laneRegA) begin                                        // see R3
      if (pendNow[`PSR_SYN_REGA]) begin
        err = 1'b1;                                            // see R4
      end else begin
        state_nxt.shRegA = busReq.wdata[15:8];                 // see R8
        state_nxt.reqTog[`PSR_SYN_REGA] = ~state_r.reqTog[`PSR_SYN_REGA];
      end
    end
    if (laneRegC) begin
      // A second byte into a pending 16-bit register is refused
      if (pendNow[`PSR_SYN_REGC]) begin
        err = 1'b1;                                            // see R7
      end else begin
        if (busReq.byteEn[`PSR_LANE_REGC_LO]) begin
          state_nxt.shRegC[7:0] = busReq.wdata[23:16];
        end
        if (busReq.byteEn[`PSR_LANE_REGC_HI]) begin
          state_nxt.shRegC[15:8] = busReq.wdata[31:24];
        end
        state_nxt.reqTog[`PSR_SYN_REGC] = ~state_r.reqTog[`PSR_SYN_REGC];
      end
    end

    // Bus-side register, no crossing
    if (busReq.valid && busReq.write && !busIfMasked
        && busReq.addr == `PSR_OFS_CFG) begin                  // see R1
      for (int b = 0; b < 4; b++) begin
        if (busReq.byteEn[b]) begin
          state_nxt.busCfg[8*b +: 8] = busReq.wdata[8*b +: 8];
        end
      end
    end

    // ***************************************************
    // Core side, stepped by generic clock edges
    // ***************************************************
    state_nxt.core.periphReset = 1'b0;
    if (coreTick) begin                                        // see R2
      // Two sync stages, then three more so the whole crossing lands
      // above five core plus two bus and below six core plus three bus periods
      state_nxt.cReqS1 = state_r.reqTog;                       // see R17
      state_nxt.cReqS2 = state_r.cReqS1;
      state_nxt.cReqS3 = state_r.cReqS2;
      state_nxt.cReqS4 = state_r.cReqS3;
      state_nxt.cReqS5 = state_r.cReqS4;
      for (int i = 0; i < `PSR_NUM_SYNC; i++) begin
        if (state_r.cReqS5[i] != state_r.cAck[i]) begin
          state_nxt.cAck[i] = state_r.cReqS5[i];               // see R20
        end
      end
      if (state_r.cReqS5[`PSR_SYN_ENABLE] != state_r.cAck[`PSR_SYN_ENABLE])
      begin
        state_nxt.core.enable = state_r.shEnable;
      end
      if (state_r.cReqS5[`PSR_SYN_REGA] != state_r.cAck[`PSR_SYN_REGA])
      begin
        state_nxt.core.regA = state_r.shRegA;
      end
      if (state_r.cReqS5[`PSR_SYN_REGC] != state_r.cAck[`PSR_SYN_REGC])
      begin
        state_nxt.core.regC = state_r.shRegC;
      end
      if (state_r.cReqS5[`PSR_SYN_SOFT_RESET_BIT] != state_r.cAck[`PSR_SYN_SOFT_RESET_BIT])
      begin
        state_nxt.core.enable      = 1'b0;
        state_nxt.core.regA        = `PSR_RST_REGA;
        state_nxt.core.regC        = `PSR_RST_REGC;
        state_nxt.core.periphReset = 1'b1;
      end
    end

    // ***************************************************
    // Bus answers
    // ***************************************************
    // Flags follow the next toggle state, so they agree with the refusal
    state_nxt.pending = state_nxt.reqTog ^ state_nxt.ackS2;    // see R6
    for (int i = 0; i < `PSR_NUM_SYNC; i++) begin
      if (state_nxt.reqTog[i] != state_r.reqTog[i]) begin
        state_nxt.pending[i] = 1'b1;
      end
    end
    state_nxt.rsp.accessError = err;                           // see R4
    // Ready event only for the data registers
    state_nxt.rsp.syncReady =
      (ackDone[`PSR_SYN_REGA] & ~pendNow[`PSR_SYN_REGA])
      | (ackDone[`PSR_SYN_REGC] & ~pendNow[`PSR_SYN_REGC]);    // see R11 R13
    state_nxt.rsp.rdValid = busReq.valid & ~busReq.write;      // see R18
    state_nxt.rsp.rdData  = 32'h0000_0000;
    if (busReq.valid && !busReq.write && !busIfMasked) begin   // see R19
      if (rdCtrl) begin
        state_nxt.rsp.rdData = {state_r.shRegC, state_r.shRegA, 6'h00,
                                state_r.shSwrst, state_r.shEnable}; // see R10
      end else if (busReq.addr == `PSR_OFS_CFG) begin
        state_nxt.rsp.rdData = state_r.busCfg;                 // see R1
      end else if (busReq.addr == `PSR_OFS_PENDING) begin
        state_nxt.rsp.rdData = {28'h0000000, pendNow};         // see R11
      end
    end
  end

  // ***************************************************
  // State register
  // ***************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign busRsp           = state_r.rsp;
  assign syncPendingFlags = state_r.pending;
  assign coreOut          = state_r.core;

endmodule // psr_sync_top

// >>> verif/psr_sync_asserts.sv
// Purpose : Port checks of the register sync block
// Assumes : Generic clock period is 8 bus clock periods
// Notes   : Bound to psr_sync_top
`timescale 1ns/1ns
`include "psr_map.svh"

module psr_sync_asserts #(
  parameter int ADDR_W = 4
) (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     genericClockIn,
  input wire logic                     busIfMasked,
  input wire psr_pkg::psr_bus_req_type busReq,
  input wire psr_pkg::psr_bus_rsp_type busRsp,
  input wire logic [`PSR_NUM_SYNC-1:0] syncPendingFlags,
  input wire psr_pkg::psr_core_type    coreOut
);
  // ***************************************************
  // Checks
  // ***************************************************
  localparam int LO = 42;
  localparam int HI = 51;
  logic       rd;
  logic       ctl;
  logic [7:0] cnt_r;
  assign rd  = busReq.valid && !busReq.write;
  assign ctl = busReq.valid && busReq.write && !busIfMasked &&
               busReq.addr == `PSR_OFS_CTRL;
  // Bus cycles a register A crossing has been pending
  always_ff @(posedge clk) begin
    if (!rst_n || !syncPendingFlags[2]) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_read_lat; rd |=> busRsp.rdValid; endproperty
  a_read_lat: assert property (p_read_lat)
    else $error("read not answered next cycle");
  property p_no_stray; !rd |=> !busRsp.rdValid; endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("read valid without read");
  property p_mask_rd; rd && busIfMasked |=> busRsp.rdData == 32'h0;
  endproperty
  a_mask_rd: assert property (p_mask_rd)
    else $error("masked read not zero");
  property p_mask_wr; busReq.valid && busReq.write && busIfMasked |=>
    !busRsp.accessError && (syncPendingFlags & ~$past(syncPendingFlags)) == 4'h0;
  endproperty
  a_mask_wr: assert property (p_mask_wr)
    else $error("masked write had effect");
  property p_err_rega; ctl && busReq.byteEn[`PSR_LANE_REGA] &&
    syncPendingFlags[`PSR_SYN_REGA] |=> busRsp.accessError; endproperty
  a_err_rega: assert property (p_err_rega)
    else $error("rewrite of pending register not refused");
  property p_set_rega; ctl && busReq.byteEn[`PSR_LANE_REGA] &&
    !syncPendingFlags[2] |=> syncPendingFlags[2]; endproperty
  a_set_rega: assert property (p_set_rega)
    else $error("pending flag not set");
  property p_err_regc; ctl && busReq.byteEn[`PSR_LANE_REGC_HI] &&
    syncPendingFlags[`PSR_SYN_REGC] |=> busRsp.accessError; endproperty
  a_err_regc: assert property (p_err_regc)
    else $error("second byte write not refused");
  property p_sync_dly; $fell(syncPendingFlags[2]) |->
    cnt_r > LO && cnt_r < HI; endproperty
  a_sync_dly: assert property (p_sync_dly)
    else $error("crossing delay out of window");
  property p_ready; busRsp.syncReady |-> $past(syncPendingFlags[3:2]) != 2'h0
    || $past(syncPendingFlags[3:2], 2) != 2'h0; endproperty
  a_ready: assert property (p_ready)
    else $error("sync ready without register crossing");
  property p_soft_reset_bit; ctl && busReq.byteEn[0] && busReq.wdata[1] &&
    syncPendingFlags[1:0] == 2'h0 |=> syncPendingFlags[1] ##[1:80]
    coreOut.periphReset; endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit)
    else $error("soft reset did not run");
  property p_swrst0; ctl && busReq.byteEn[0] && !busReq.wdata[1] |=>
    !syncPendingFlags[1] || $past(syncPendingFlags[1]); endproperty
  a_swrst0: assert property (p_swrst0)
    else $error("zero to soft reset had effect");
  c_ready: cover property (busRsp.syncReady);
  c_error: cover property (busRsp.accessError);
  c_reset: cover property (coreOut.periphReset);
endmodule // psr_sync_asserts

bind psr_sync_top psr_sync_asserts #(.ADDR_W(ADDR_W)) i_psr_sync_asserts (
  .clk(clk), .rst_n(rst_n), .genericClockIn(genericClockIn),
  .busIfMasked(busIfMasked), .busReq(busReq), .busRsp(busRsp),
  .syncPendingFlags(syncPendingFlags), .coreOut(coreOut));

// >>> verif/psr_bus_master.sv
// Purpose : Bus master on the far side of the register sync block
// Assumes : Tasks are entered at a falling clock edge
// Notes   : Idle cycles carry changing junk under a low valid
`timescale 1ns/1ns
`include "psr_map.svh"

module psr_bus_master (
  input  wire logic                     clk,
  output      psr_pkg::psr_bus_req_type busReq,
  input  wire psr_pkg::psr_bus_rsp_type busRsp,
  input  wire logic [`PSR_NUM_SYNC-1:0] syncPendingFlags
);
  // ***************************************************
  // Requests
  // ***************************************************
  initial busReq = '0;
  task automatic access(input logic wr, input logic [3:0] addr,
    input logic [31:0] d, input logic [3:0] be,
    output psr_pkg::psr_bus_rsp_type rsp);
    busReq = '{1'h1, wr, addr, d, be};
    @(negedge clk);
    rsp = busRsp;
  endtask
  task automatic idle();
    busReq = '{1'h0, 1'h0, ~busReq.addr, ~busReq.wdata, ~busReq.byteEn};
    @(negedge clk);
  endtask
  // Polls the pending register before reuse or read of a core register
  task automatic wait_sync(input logic [3:0] mask, output logic ok);
    psr_pkg::psr_bus_rsp_type rsp;
    ok = 1'h0;
    for (int i = 0; i < 200 && !ok; i++) begin
      access(1'h0, `PSR_OFS_PENDING, 32'h0, 4'hf, rsp);
      ok = (rsp.rdData[3:0] & mask) == 4'h0;
    end
  endtask
endmodule // psr_bus_master

// >>> verif/psr_testbench.sv
// Purpose : Self-checking bench of the register sync block
// Assumes : Generic clock runs at one eighth of the bus clock
// Notes   : Random data from a fixed seed
`timescale 1ns/1ns
`include "psr_map.svh"

module testbench;
  // ***************************************************
  // Bench
  // ***************************************************
  logic                     clk;
  logic                     rst_n;
  logic                     genClk;
  logic                     busIfMasked;
  psr_pkg::psr_bus_req_type busReq;
  psr_pkg::psr_bus_rsp_type busRsp;
  psr_pkg::psr_bus_rsp_type rsp;
  psr_pkg::psr_core_type    coreOut;
  logic [3:0]               syncPendingFlags;
  logic                     ok;
  logic [31:0]              cfg;
  logic [7:0]               a;
  logic [15:0]              c;
  int                       failures;
  int                       checks;
  int                       readyCnt = 0;
  int                       readyRef;
  psr_sync_top i_psr_sync_top (.clk(clk), .rst_n(rst_n),
    .genericClockIn(genClk), .busIfMasked(busIfMasked), .busReq(busReq),
    .busRsp(busRsp), .syncPendingFlags(syncPendingFlags), .coreOut(coreOut));
  psr_bus_master i_psr_bus_master (.clk(clk), .busReq(busReq),
    .busRsp(busRsp), .syncPendingFlags(syncPendingFlags));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Counts ready pulses away from the edge that launches them
  always @(negedge clk) begin
    if (busRsp.syncReady === 1'h1) begin
      readyCnt++;
    end
  end
  initial begin
    genClk = 1'h0;
    #7;
    forever #160 genClk = ~genClk;
  end
  function automatic logic [31:0] ctrl_word(input logic en, input logic sw,
    input logic [7:0] ra, input logic [15:0] rc);
    return {rc, ra, 6'h00, sw, en};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] d,
    input logic [3:0] be);
    i_psr_bus_master.access(1'h1, ad, d, be, rsp);
  endtask
  task automatic rd(input logic [3:0] ad);
    i_psr_bus_master.access(1'h0, ad, 32'h0, 4'hf, rsp);
  endtask
  task automatic stop_test();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #(20000 * 40);
    failures++;
    stop_test();
  end
  initial begin
    failures = 0;
    checks = 0;
    rst_n = 1'h0;
    busIfMasked = 1'h0;
    void'($urandom(32'h4ba3));
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    chk("reset flags", 32'h0, {28'h0, syncPendingFlags});
    cfg = $urandom();
    wr(`PSR_OFS_CFG, cfg, 4'hf);
    rd(`PSR_OFS_CFG);
    chk("cfg read", cfg, rsp.rdData);
    chk("cfg valid", 32'h1, {31'h0, rsp.rdValid});
    chk("cfg flags", 32'h0, {28'h0, syncPendingFlags});
    rd(4'hc);
    chk("unmapped read", 32'h0, rsp.rdData);
    a = $urandom();
    c = $urandom();
    wr(`PSR_OFS_CTRL, {16'h0, a, 8'h0}, 4'h2);
    chk("rega error", 32'h0, {31'h0, rsp.accessError});
    wr(`PSR_OFS_CTRL, {8'h0, c[7:0], 16'h0}, 4'h4);
    chk("regc low error", 32'h0, {31'h0, rsp.accessError});
    wr(`PSR_OFS_CTRL, {c[15:8], 24'h0}, 4'h8);
    chk("regc high error", 32'h1, {31'h0, rsp.accessError});
    wr(`PSR_OFS_CTRL, {16'h0, ~a, 8'h0}, 4'h2);
    chk("rega again error", 32'h1, {31'h0, rsp.accessError});
    chk("flags", 32'hc, {28'h0, syncPendingFlags});
    rd(`PSR_OFS_CTRL);
    chk("ctrl", ctrl_word(1'h0, 1'h0, a, {8'h0, c[7:0]}), rsp.rdData);
    i_psr_bus_master.wait_sync(4'hc, ok);
    chk("core", {6'h0, 2'h0, a, 8'h0, c[7:0]}, {6'h0, coreOut});
    for (int i = 0; i < 3; i++) begin
      a = $urandom();
      c = $urandom();
      wr(`PSR_OFS_CTRL, ctrl_word(1'h1, 1'h0, a, c), 4'hf);
      chk("word error", 32'h0, {31'h0, rsp.accessError});
      chk("word flags", 32'hd, {28'h0, syncPendingFlags});
      rd(`PSR_OFS_CTRL);
      chk("word read", ctrl_word(1'h1, 1'h0, a, c), rsp.rdData);
      i_psr_bus_master.wait_sync(4'hf, ok);
      chk("word done", 32'h1, {31'h0, ok});
      chk("word core", {6'h0, 2'h2, a, c}, {6'h0, coreOut});
    end
    wr(`PSR_OFS_CTRL, 32'h2, 4'h1);
    readyRef = readyCnt;
    chk("ready count", 32'h1, {31'h0, readyCnt >= 4});
    rd(`PSR_OFS_CTRL);
    chk("soft_reset_bit read", 32'h2, rsp.rdData & 32'h2);
    i_psr_bus_master.wait_sync(4'h3, ok);
    rd(`PSR_OFS_CTRL);
    chk("ctrl cleared", 32'h0, rsp.rdData);
    chk("soft_reset_bit done", 32'h1, {31'h0, ok});
    chk("soft_reset_bit ready", readyRef, readyCnt);
    wr(`PSR_OFS_CFG, cfg, 4'hf);
    busIfMasked = 1'h1;
    wr(`PSR_OFS_CFG, ~cfg, 4'hf);
    rd(`PSR_OFS_CFG);
    chk("masked read", 32'h0, rsp.rdData);
    busIfMasked = 1'h0;
    rd(`PSR_OFS_CFG);
    chk("masked write", cfg, rsp.rdData);
    i_psr_bus_master.idle();
    stop_test();
  end
endmodule // testbench
